// ===== logic/hssp_defs.svh
// Offsets, field positions, reset values and response codes of the status bank.
`ifndef HSSP_DEFS_SVH
`define HSSP_DEFS_SVH

`define HSSP_ADDR_W 8
`define HSSP_OFF_HS_STATUS 8'h00
`define HSSP_OFF_POLL_BYTE 8'h04
`define HSSP_OFF_HS_DECODE 8'h08

`define HSSP_HS_NEW_BYTE 7
`define HSSP_HS_END_HOLDOFF 6
`define HSSP_HS_NR_HOLDOFF 5
`define HSSP_HS_NR_HOLDOFF_IMM 4
`define HSSP_HS_DATA_HOLDOFF 3
`define HSSP_HS_ACC_READY 2
`define HSSP_HS_SRC_A 1
`define HSSP_HS_SRC_B 0

`define HSSP_POLL_SRQ_BIT 6
`define HSSP_POLL_RESET 8'h00

`define HSSP_DEC_ACC_IDLE 0
`define HSSP_DEC_ACC_NRDY 1
`define HSSP_DEC_ACC_RDY 2
`define HSSP_DEC_ACC_DATA 3
`define HSSP_DEC_SRC_IDLE 4
`define HSSP_DEC_SRC_GEN 5
`define HSSP_DEC_SRC_DLY 6
`define HSSP_DEC_SRC_XFER 7

`define HSSP_RESP_OKAY 2'h0
`define HSSP_RESP_SLVERR 2'h2

`endif

// ===== logic/hssp_hs_decode.sv
// Decodes acceptor and source handshake states from the status bits.
`timescale 1ns/100ps
`default_nettype none
`include "hssp_defs.svh"

module hssp_hs_decode (
  // Clock and reset for the checks.
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Handshake status inputs.
  input wire logic i_atn,
  input wire logic i_listener_addr,
  input wire logic i_talker_active,
  input wire logic i_cic,
  input wire logic i_dav,
  input wire logic i_acceptor_ready_flag,
  input wire logic i_data_holdoff_state,
  input wire logic i_source_state_bit_a,
  input wire logic i_source_state_bit_b,
  // Decoded states, one bit each.
  output logic [7:0] o_states
);

  logic acc_idle;
  logic src_idle;

  always_comb begin
    acc_idle = ~i_atn & ~i_listener_addr;
    src_idle = ~((i_talker_active & ~i_atn) | (i_cic & i_atn));
    o_states = 8'h00;
    o_states[`HSSP_DEC_ACC_IDLE] = acc_idle;
    o_states[`HSSP_DEC_ACC_NRDY] = ~acc_idle & ~i_acceptor_ready_flag & ~i_dav;
    o_states[`HSSP_DEC_ACC_RDY] = ~acc_idle & i_acceptor_ready_flag & ~i_dav;
    o_states[`HSSP_DEC_ACC_DATA] = ~acc_idle & i_dav &
        (i_acceptor_ready_flag | i_data_holdoff_state);
    o_states[`HSSP_DEC_SRC_IDLE] = src_idle;
    o_states[`HSSP_DEC_SRC_GEN] = ~src_idle & ~i_source_state_bit_a &
        ~i_source_state_bit_b;
    o_states[`HSSP_DEC_SRC_DLY] = ~src_idle & i_source_state_bit_a;
    o_states[`HSSP_DEC_SRC_XFER] = ~src_idle & ~i_source_state_bit_a &
        i_source_state_bit_b;
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  a_acc_ready_excl: assert property (
    o_states[`HSSP_DEC_ACC_RDY] |-> !o_states[`HSSP_DEC_ACC_NRDY] && !i_dav && !acc_idle)
    else $error("Acceptor ready state decoded wrongly.");

  a_acc_idle_quiet: assert property (
    (!i_atn && !i_listener_addr) |-> o_states[3:1] == 3'h0)
    else $error("Idle acceptor reports an active state.");

  a_src_one_state: assert property (
    !src_idle |-> $onehot({o_states[`HSSP_DEC_SRC_GEN], o_states[`HSSP_DEC_SRC_DLY],
        o_states[`HSSP_DEC_SRC_XFER]}))
    else $error("Active source must show exactly one state.");

endmodule // hssp_hs_decode
`default_nettype wire

// ===== logic/hssp_pkg.sv
// Types shared by the handshake status and serial poll bank.
package hssp_pkg;

  typedef enum logic [1:0] {REG_HS_STATUS, REG_POLL_BYTE, REG_HS_DECODE, REG_NONE} hssp_reg_t;

  typedef enum logic [0:0] {WR_IDLE, WR_RESP} hssp_wr_t;

  typedef enum logic [0:0] {RD_IDLE, RD_RESP} hssp_rd_t;

  typedef struct packed {
    hssp_wr_t wr_st;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [7:0] w_data;
    logic w_lane0;
    logic [1:0] bresp;
    hssp_rd_t rd_st;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } hssp_bus_t;

  typedef struct packed {
    logic [7:0] status;
    logic req_pending;
    logic srq;
  } hssp_poll_t;

endpackage

// ===== logic/hssp_poll.sv
// Serial poll status byte, service request control and pending flag.
`timescale 1ns/100ps
`default_nettype none
`include "hssp_defs.svh"

module hssp_poll (
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Host write of the poll status byte.
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  // Bus-side poll events.
  input wire logic i_poll_active,
  input wire logic i_stb_read,
  input wire logic i_neg_poll_resp,
  // Status outputs.
  output logic [7:0] o_read_view,
  output logic o_rsv,
  output logic o_req_pending,
  output logic o_srq
);

  hssp_pkg::hssp_poll_t st_ff;
  hssp_pkg::hssp_poll_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (i_wr) begin
      nxt_st.status = i_wdata;
    end
    // A host write that raises the request wins over a clear by the poll.
    if (i_wr && i_wdata[`HSSP_POLL_SRQ_BIT]) begin
      nxt_st.status[`HSSP_POLL_SRQ_BIT] = 1'b1;
    end else if (i_stb_read) begin
      nxt_st.status[`HSSP_POLL_SRQ_BIT] = 1'b0;
    end
    if (st_ff.status[`HSSP_POLL_SRQ_BIT]) begin
      nxt_st.req_pending = 1'b1;
    end else if (i_neg_poll_resp) begin
      nxt_st.req_pending = 1'b0;
    end
    nxt_st.srq = nxt_st.status[`HSSP_POLL_SRQ_BIT] & ~i_poll_active;
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_comb begin
    o_read_view = st_ff.status;
    o_read_view[`HSSP_POLL_SRQ_BIT] = st_ff.req_pending;
    o_rsv = st_ff.status[`HSSP_POLL_SRQ_BIT];
    o_req_pending = st_ff.req_pending;
    o_srq = st_ff.srq;
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  a_pending_follows_rsv: assert property (
    o_rsv |=> o_req_pending)
    else $error("Pending flag did not follow the service request.");

  a_pending_clears: assert property (
    (!o_rsv && i_neg_poll_resp && o_req_pending) |=> !o_req_pending)
    else $error("Pending flag did not clear in negative poll response.");

  a_rsv_cleared_by_poll: assert property (
    (i_stb_read && !i_wr) |=> !o_rsv)
    else $error("Service request not cleared after the status byte was read.");

  a_srq_gated: assert property (
    o_srq |-> o_rsv && !$past(i_poll_active))
    else $error("Service request asserted during a poll or without request.");

endmodule // hssp_poll
`default_nettype wire

// ===== logic/hssp_regs.sv
// Handshake status and serial poll register bank with an AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "hssp_defs.svh"

module hssp_regs (
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_rst,
  // AXI4-Lite write address channel.
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [7:0] i_s_axi_awaddr,
  input wire logic [2:0] i_s_axi_awprot,
  // AXI4-Lite write data channel.
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  // AXI4-Lite write response channel.
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  output logic [1:0] o_s_axi_bresp,
  // AXI4-Lite read address channel.
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  input wire logic [7:0] i_s_axi_araddr,
  input wire logic [2:0] i_s_axi_arprot,
  // AXI4-Lite read data channel.
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  // Acceptor handshake status from the handshake engine.
  input wire logic i_new_byte_avail,
  input wire logic i_end_holdoff_state,
  input wire logic i_not_ready_holdoff,
  input wire logic i_not_ready_holdoff_immediate,
  input wire logic i_data_holdoff_state,
  input wire logic i_acceptor_ready_flag,
  // Source handshake status from the handshake engine.
  input wire logic i_source_state_bit_a,
  input wire logic i_source_state_bit_b,
  // Bus and addressing status.
  input wire logic i_atn,
  input wire logic i_dav,
  input wire logic i_listener_addr,
  input wire logic i_talker_active,
  input wire logic i_cic,
  // Serial poll events from the talker function.
  input wire logic i_poll_active,
  input wire logic i_stb_read,
  input wire logic i_neg_poll_resp,
  // Service request outputs.
  output logic o_rsv,
  output logic o_req_pending,
  output logic o_srq
);

  hssp_pkg::hssp_bus_t st_ff;
  hssp_pkg::hssp_bus_t nxt_st;

  logic [7:0] hs_status;
  logic [7:0] hs_states;
  logic [7:0] poll_view;
  logic poll_wr;
  logic [7:0] rd_mux;
  logic [1:0] rd_resp;
  logic aw_take;
  logic w_take;
  hssp_pkg::hssp_reg_t wr_sel;
  hssp_pkg::hssp_reg_t rd_sel;

  // Maps a word address to a register; low address bits are ignored.
  function automatic hssp_pkg::hssp_reg_t reg_sel(input logic [7:0] addr);
    case ({addr[7:2], 2'h0})
      `HSSP_OFF_HS_STATUS: reg_sel = hssp_pkg::REG_HS_STATUS;
      `HSSP_OFF_POLL_BYTE: reg_sel = hssp_pkg::REG_POLL_BYTE;
      `HSSP_OFF_HS_DECODE: reg_sel = hssp_pkg::REG_HS_DECODE;
      default: reg_sel = hssp_pkg::REG_NONE;
    endcase
  endfunction

  // Live handshake status word, sampled only when a read is taken.
  always_comb begin
    hs_status = 8'h00;
    hs_status[`HSSP_HS_NEW_BYTE] = i_new_byte_avail;
    hs_status[`HSSP_HS_END_HOLDOFF] = i_end_holdoff_state;
    hs_status[`HSSP_HS_NR_HOLDOFF] = i_not_ready_holdoff;
    hs_status[`HSSP_HS_NR_HOLDOFF_IMM] = i_not_ready_holdoff_immediate;
    hs_status[`HSSP_HS_DATA_HOLDOFF] = i_data_holdoff_state;
    hs_status[`HSSP_HS_ACC_READY] = i_acceptor_ready_flag;
    hs_status[`HSSP_HS_SRC_A] = i_source_state_bit_a;
    hs_status[`HSSP_HS_SRC_B] = i_source_state_bit_b;
  end

  hssp_hs_decode u_decode (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_atn(i_atn),
    .i_listener_addr(i_listener_addr),
    .i_talker_active(i_talker_active),
    .i_cic(i_cic),
    .i_dav(i_dav),
    .i_acceptor_ready_flag(i_acceptor_ready_flag),
    .i_data_holdoff_state(i_data_holdoff_state),
    .i_source_state_bit_a(i_source_state_bit_a),
    .i_source_state_bit_b(i_source_state_bit_b),
    .o_states(hs_states)
  );

  hssp_poll u_poll (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_wr(poll_wr),
    .i_wdata(st_ff.w_data),
    .i_poll_active(i_poll_active),
    .i_stb_read(i_stb_read),
    .i_neg_poll_resp(i_neg_poll_resp),
    .o_read_view(poll_view),
    .o_rsv(o_rsv),
    .o_req_pending(o_req_pending),
    .o_srq(o_srq)
  );

  // Write and read decode share one address map.
  always_comb begin
    wr_sel = reg_sel(st_ff.aw_addr);
    rd_sel = reg_sel(i_s_axi_araddr);
    rd_mux = 8'h00;
    rd_resp = `HSSP_RESP_OKAY;
    case (rd_sel)
      hssp_pkg::REG_HS_STATUS: rd_mux = hs_status;
      hssp_pkg::REG_POLL_BYTE: rd_mux = poll_view;
      hssp_pkg::REG_HS_DECODE: rd_mux = hs_states;
      default: rd_resp = `HSSP_RESP_SLVERR;
    endcase
  end

  // The poll byte is the only writable register; lane 0 carries it.
  always_comb begin
    poll_wr = (st_ff.wr_st == hssp_pkg::WR_IDLE) && st_ff.aw_got && st_ff.w_got &&
        (wr_sel == hssp_pkg::REG_POLL_BYTE) && st_ff.w_lane0;
  end

  always_comb begin
    o_s_axi_awready = (st_ff.wr_st == hssp_pkg::WR_IDLE) && !st_ff.aw_got;
    o_s_axi_wready = (st_ff.wr_st == hssp_pkg::WR_IDLE) && !st_ff.w_got;
    o_s_axi_bvalid = (st_ff.wr_st == hssp_pkg::WR_RESP);
    o_s_axi_bresp = st_ff.bresp;
    o_s_axi_arready = (st_ff.rd_st == hssp_pkg::RD_IDLE);
    o_s_axi_rvalid = (st_ff.rd_st == hssp_pkg::RD_RESP);
    o_s_axi_rdata = {24'h000000, st_ff.rdata};
    o_s_axi_rresp = st_ff.rresp;
    aw_take = i_s_axi_awvalid && o_s_axi_awready;
    w_take = i_s_axi_wvalid && o_s_axi_wready;
  end

  // Bus state: address and data are caught in either order, answered once both are in.
  always_comb begin
    nxt_st = st_ff;
    case (st_ff.wr_st)
      hssp_pkg::WR_IDLE: begin
        if (aw_take) begin
          nxt_st.aw_got = 1'b1;
          nxt_st.aw_addr = i_s_axi_awaddr;
        end
        if (w_take) begin
          nxt_st.w_got = 1'b1;
          nxt_st.w_data = i_s_axi_wdata[7:0];
          nxt_st.w_lane0 = i_s_axi_wstrb[0];
        end
        if (st_ff.aw_got && st_ff.w_got) begin
          nxt_st.wr_st = hssp_pkg::WR_RESP;
          nxt_st.bresp = (wr_sel == hssp_pkg::REG_POLL_BYTE) ?
              `HSSP_RESP_OKAY : `HSSP_RESP_SLVERR;
        end
      end
      hssp_pkg::WR_RESP: begin
        if (i_s_axi_bready) begin
          nxt_st.wr_st = hssp_pkg::WR_IDLE;
          nxt_st.aw_got = 1'b0;
          nxt_st.w_got = 1'b0;
        end
      end
      default: nxt_st.wr_st = hssp_pkg::WR_IDLE;
    endcase
    case (st_ff.rd_st)
      hssp_pkg::RD_IDLE: begin
        if (i_s_axi_arvalid) begin
          nxt_st.rd_st = hssp_pkg::RD_RESP;
          nxt_st.rdata = rd_mux;
          nxt_st.rresp = rd_resp;
        end
      end
      hssp_pkg::RD_RESP: begin
        if (i_s_axi_rready) begin
          nxt_st.rd_st = hssp_pkg::RD_IDLE;
        end
      end
      default: nxt_st.rd_st = hssp_pkg::RD_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  sequence s_hs_read;
    i_s_axi_arvalid && o_s_axi_arready &&
        (reg_sel(i_s_axi_araddr) == hssp_pkg::REG_HS_STATUS);
  endsequence

  sequence s_poll_read;
    i_s_axi_arvalid && o_s_axi_arready &&
        (reg_sel(i_s_axi_araddr) == hssp_pkg::REG_POLL_BYTE);
  endsequence

  sequence s_dec_read;
    i_s_axi_arvalid && o_s_axi_arready &&
        (reg_sel(i_s_axi_araddr) == hssp_pkg::REG_HS_DECODE);
  endsequence

  a_hs_read_live: assert property (
    s_hs_read |=> o_s_axi_rvalid && o_s_axi_rdata[7:0] == $past(hs_status) &&
        o_s_axi_rdata[31:8] == 24'h000000)
    else $error("Handshake status read does not return the live bits.");

  a_hs_src_bits: assert property (
    s_hs_read |=> o_s_axi_rdata[1:0] ==
        $past({i_source_state_bit_a, i_source_state_bit_b}))
    else $error("Source state bits misplaced in handshake status.");

  a_hs_read_pure: assert property (
    s_hs_read |=> $stable(o_rsv) || $past(i_stb_read) || $past(poll_wr))
    else $error("Handshake status read disturbed the poll state.");

  a_poll_read_view: assert property (
    s_poll_read |=> o_s_axi_rdata[6] == $past(o_req_pending) &&
        o_s_axi_rdata[7] == $past(poll_view[7]))
    else $error("Poll read view does not report the pending flag.");

  a_poll_write_rsv: assert property (
    poll_wr && st_ff.w_data[6] |=> o_rsv ##1 o_req_pending)
    else $error("Written request bit did not raise request and pending.");

  a_write_answer: assert property (
    (st_ff.aw_got && st_ff.w_got && st_ff.wr_st == hssp_pkg::WR_IDLE) |=>
        o_s_axi_bvalid [*1] ##0 (o_s_axi_bresp == $past(wr_sel == hssp_pkg::REG_POLL_BYTE ?
        `HSSP_RESP_OKAY : `HSSP_RESP_SLVERR)))
    else $error("Write response wrong or late.");

  a_bvalid_holds: assert property (
    (o_s_axi_bvalid && !i_s_axi_bready) |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
    else $error("Write response dropped before it was taken.");

  a_rvalid_holds: assert property (
    (o_s_axi_rvalid && !i_s_axi_rready) |=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
    else $error("Read data dropped before it was taken.");

  a_acc_data_read: assert property (
    s_dec_read ##0 (i_listener_addr && i_dav &&
        (i_acceptor_ready_flag || i_data_holdoff_state)) |=>
        o_s_axi_rdata[`HSSP_DEC_ACC_DATA])
    else $error("Acceptor data state missing from decode read.");

  a_src_idle_read: assert property (
    ((reg_sel(i_s_axi_araddr) == hssp_pkg::REG_HS_DECODE) && i_s_axi_arvalid &&
        o_s_axi_arready && !i_cic && !i_talker_active) |=>
        o_s_axi_rdata[`HSSP_DEC_SRC_IDLE] && o_s_axi_rdata[7:5] == 3'h0)
    else $error("Source handshake should read idle.");

  a_src_xfer_read: assert property (
    ((reg_sel(i_s_axi_araddr) == hssp_pkg::REG_HS_DECODE) && i_s_axi_arvalid &&
        o_s_axi_arready && i_cic && i_atn && !i_source_state_bit_a &&
        i_source_state_bit_b) |=> o_s_axi_rdata[`HSSP_DEC_SRC_XFER])
    else $error("Source transfer state missing from decode read.");

endmodule // hssp_regs
`default_nettype wire

// ===== sim/hssp_ctrl_model.sv
// Controller-side model: bus status levels and serial poll sequences.
`timescale 1ns/100ps
`default_nettype none

module hssp_ctrl_model (
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Bench controls.
  input wire logic [4:0] i_bus_pat,
  input wire logic i_poll_go,
  input wire logic i_slow,
  // Bus and addressing levels towards the device.
  output logic o_atn,
  output logic o_dav,
  output logic o_listener_addr,
  output logic o_talker_active,
  output logic o_cic,
  // Serial poll events.
  output logic o_poll_active,
  output logic o_stb_read,
  output logic o_neg_poll_resp,
  output logic o_poll_done
);
  int cnt;
  int stb_at;

  // A poll raises the active level, reads the status byte once inside it, then
  // leaves the device in negative poll response for three cycles.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt <= 0;
      stb_at <= 3;
      {o_atn, o_dav, o_listener_addr, o_talker_active, o_cic} <= 5'h00;
      {o_poll_active, o_stb_read, o_neg_poll_resp, o_poll_done} <= 4'h0;
    end else begin
      {o_atn, o_dav, o_listener_addr, o_talker_active, o_cic} <= i_bus_pat;
      o_stb_read <= 1'b0;
      o_poll_done <= 1'b0;
      if (i_poll_go && cnt == 0) begin
        cnt <= 1;
        stb_at <= i_slow ? 8 : 3;
      end else if (cnt != 0) begin
        cnt <= cnt + 1;
        o_poll_active <= cnt <= stb_at;
        o_stb_read <= cnt == stb_at;
        o_neg_poll_resp <= cnt > stb_at && cnt < stb_at + 4;
        if (cnt == stb_at + 5) begin
          cnt <= 0;
          o_poll_done <= 1'b1;
        end
      end
    end
  end
endmodule // hssp_ctrl_model

`default_nettype wire

// ===== sim/hssp_regs_test.sv
// Self-checking bench for the handshake status and serial poll bank.
`timescale 1ns/100ps
`default_nettype none
`include "hssp_defs.svh"

module hssp_regs_test;
  logic core_clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr, hs;
  logic [31:0] wdata, rdata, got, v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic [4:0] bus_pat;
  logic poll_go, slow, poll_done, atn, dav, la, ta, cic, poll_act, stb_rd, npr;
  logic rsv, req_pending, srq;
  int err_count, n_checks, seed, m_stat;
  bit m_rsv, m_pending;

  hssp_regs dut (.i_core_clk(core_clk), .i_rst(rst),
    .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_awaddr(awaddr),
    .i_s_axi_awprot(3'h0), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
    .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .o_s_axi_bvalid(bvalid),
    .i_s_axi_bready(bready), .o_s_axi_bresp(bresp), .i_s_axi_arvalid(arvalid),
    .o_s_axi_arready(arready), .i_s_axi_araddr(araddr), .i_s_axi_arprot(3'h0),
    .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .o_s_axi_rdata(rdata),
    .o_s_axi_rresp(rresp), .i_new_byte_avail(hs[7]), .i_end_holdoff_state(hs[6]),
    .i_not_ready_holdoff(hs[5]), .i_not_ready_holdoff_immediate(hs[4]),
    .i_data_holdoff_state(hs[3]), .i_acceptor_ready_flag(hs[2]),
    .i_source_state_bit_a(hs[1]), .i_source_state_bit_b(hs[0]), .i_atn(atn), .i_dav(dav),
    .i_listener_addr(la), .i_talker_active(ta), .i_cic(cic), .i_poll_active(poll_act),
    .i_stb_read(stb_rd), .i_neg_poll_resp(npr), .o_rsv(rsv), .o_req_pending(req_pending),
    .o_srq(srq));

  hssp_ctrl_model ctrl (.i_core_clk(core_clk), .i_rst(rst), .i_bus_pat(bus_pat),
    .i_poll_go(poll_go), .i_slow(slow), .o_atn(atn), .o_dav(dav), .o_listener_addr(la),
    .o_talker_active(ta), .o_cic(cic), .o_poll_active(poll_act), .o_stb_read(stb_rd),
    .o_neg_poll_resp(npr), .o_poll_done(poll_done));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic close_out;
    $display("Checks %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic hang;
    err_count++;
    $display("Error at %0t: got %h expected %h, no answer", $time, 1'b0, 1'b1);
    close_out();
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    bit done;
    done = 0;
    @(posedge core_clk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    for (int i = 0; i < 50 && !done; i++) begin
      @(posedge core_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        resp = bresp;
        bready <= 1'b0;
        done = 1;
      end
    end
    if (!done) hang();
  endtask

  task automatic axi_rd(input logic [7:0] a);
    bit done;
    done = 0;
    @(posedge core_clk);
    arvalid <= 1'b1;
    rready <= 1'b1;
    araddr <= a;
    for (int i = 0; i < 50 && !done; i++) begin
      @(posedge core_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        got = rdata;
        resp = rresp;
        rready <= 1'b0;
        done = 1;
      end
    end
    if (!done) hang();
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    axi_rd(a);
    chk(got, e);
    chk({30'h0, resp}, {30'h0, er});
  endtask

  task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] er);
    axi_wr(a, d, s);
    chk({30'h0, resp}, {30'h0, er});
  endtask

  // Poll byte write through the model, then flags and read view compared.
  task automatic poll_wr(input logic [7:0] d, input logic [3:0] s);
    wr_chk(`HSSP_OFF_POLL_BYTE, {24'h0, d}, s, `HSSP_RESP_OKAY);
    if (s[0]) begin
      m_stat = d;
      m_rsv = d[6];
    end
    repeat (3) @(posedge core_clk);
    if (m_rsv) m_pending = 1;
    flags_chk();
    rd_chk(`HSSP_OFF_POLL_BYTE, view_exp(), `HSSP_RESP_OKAY);
  endtask

  task automatic flags_chk;
    chk({29'h0, rsv, req_pending, srq}, {29'h0, m_rsv, m_pending, m_rsv && !poll_act});
  endtask

  function automatic logic [31:0] view_exp;
    return {24'h0, m_stat[7], m_pending, m_stat[5:0]};
  endfunction

  // Bus pattern order: ATN, DAV, listener, talker active, in charge.
  function automatic logic [7:0] dec_exp(input logic [7:0] h, input logic [4:0] b);
    logic aids, sids;
    logic [7:0] e;
    aids = !b[4] && !b[2];
    sids = !((b[1] && !b[4]) || (b[0] && b[4]));
    e = {!sids && !h[1] && h[0], !sids && h[1], !sids && !h[1] && !h[0], sids,
         !aids && b[3] && (h[2] || h[3]), !aids && h[2] && !b[3],
         !aids && !h[2] && !b[3], aids};
    return e;
  endfunction

  task automatic run_poll(input logic sl);
    @(posedge core_clk);
    slow <= sl;
    poll_go <= 1'b1;
    @(posedge core_clk);
    poll_go <= 1'b0;
    for (int i = 0; i < 20 && !poll_act; i++) @(posedge core_clk);
    if (!poll_act) hang();
    repeat (2) @(posedge core_clk);
    chk({31'h0, srq}, 32'h0);
    for (int i = 0; i < 40 && !poll_done; i++) @(posedge core_clk);
    if (!poll_done) hang();
    m_rsv = 0;
    m_pending = 0;
    repeat (2) @(posedge core_clk);
    flags_chk();
    rd_chk(`HSSP_OFF_POLL_BYTE, view_exp(), `HSSP_RESP_OKAY);
  endtask

  initial begin
    seed = 96;
    {err_count, n_checks, m_stat, m_rsv, m_pending} = 0;
    {rst, awvalid, wvalid, bready, arvalid, rready, poll_go, slow} = 8'h80;
    {awaddr, araddr, hs, wdata, wstrb, bus_pat} = 0;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    flags_chk();
    rd_chk(`HSSP_OFF_POLL_BYTE, 32'h0, `HSSP_RESP_OKAY);
    $display("Test reset values done");
    for (int i = 0; i < 32; i++) begin
      @(posedge core_clk);
      v = $random(seed);
      hs <= v[7:0];
      bus_pat <= v[12:8];
      repeat (3) @(posedge core_clk);
      rd_chk(`HSSP_OFF_HS_STATUS, {24'h0, hs}, `HSSP_RESP_OKAY);
      rd_chk(`HSSP_OFF_HS_DECODE, {24'h0, dec_exp(hs, bus_pat)}, `HSSP_RESP_OKAY);
      rd_chk(`HSSP_OFF_HS_STATUS, {24'h0, hs}, `HSSP_RESP_OKAY);
    end
    $display("Test handshake status done");
    poll_wr(8'hC5, 4'h1);
    run_poll(1'b1);
    $display("Test slow poll done");
    poll_wr(8'h3A, 4'h1);
    poll_wr(8'hFF, 4'h0);
    poll_wr(8'h40, 4'hF);
    run_poll(1'b0);
    $display("Test prompt poll done");
    v = $random(seed);
    poll_wr(v[7:0], 4'h1);
    wr_chk(`HSSP_OFF_HS_STATUS, 32'hFF, 4'h1, `HSSP_RESP_SLVERR);
    wr_chk(`HSSP_OFF_HS_DECODE, 32'hFF, 4'h1, `HSSP_RESP_SLVERR);
    wr_chk(8'h0C, 32'hFF, 4'h1, `HSSP_RESP_SLVERR);
    rd_chk(8'h0C, 32'h0, `HSSP_RESP_SLVERR);
    rd_chk(`HSSP_OFF_POLL_BYTE, view_exp(), `HSSP_RESP_OKAY);
    $display("Test refused accesses done");
    close_out();
  end
endmodule // hssp_regs_test

`default_nettype wire
